// file: verilog/panel_pkg.sv
package panel_pkg;

  localparam int CLK_MHZ = 200;
  localparam int GAP_TIME_NS = 1000;
  localparam int DSEL_TIME_NS = 10000;
  localparam int DEBOUNCE_TIME_NS = 5000;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int GAP_CYCLES = GAP_TIME_NS / CLK_PERIOD_NS;
  localparam int DSEL_CYCLES = DSEL_TIME_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam int ADDR_LO_POS = 0;
  localparam int ADDR_HI_POS = 8;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_LOW = 2'b01,
    LD_HIGH = 2'b10
  } load_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic common_memory_select;
    logic operation_request;
    logic write_line;
    logic write_strobe_pulse;
    logic mem_not_io;
  } bus_drive_s;

  typedef struct packed {
    logic run_lamp;
    logic step_lamp;
    logic master_lamp;
    logic slave_lamp;
    logic test_lamp;
  } lamps_s;

endpackage : panel_pkg

// file: verilog/debounce.sv
`timescale 1ns/1ps
`default_nettype none
module debounce
  import panel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic raw,
  output logic clean,
  output logic rise
);
  logic [CNT_W-1:0] cnt_q;
  logic stable_q;
  logic prev_q;

  // a level must hold for the full debounce time before it is accepted
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      stable_q <= 1'b0;
    end else if (raw == stable_q) begin
      cnt_q <= '0;
    end else if (cnt_q == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
      cnt_q <= '0;
      stable_q <= raw;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= stable_q;
    end
  end

  assign clean = stable_q;
  assign rise = stable_q & ~prev_q;
endmodule : debounce
`default_nettype wire

// file: verilog/front_panel_bus_control.sv
// Behaviour
// - match needs 16 address bits plus memory-select
// - breakpoint switch gates match onto panel hold
// - scope sync is match AND operation request
// - two-stage mux: address byte, then data
// - enter picks data; sequencer picks address byte
// - access pauses CPUs, drives bus after run
// - load flop starts sequencer, low then high
// - step address and fire request gap pulse
// - enter fires data-select and request gap pulses
// - data-select drives mux, write and strobe
// - enter-next increments address before writing
// - memory-select and mem/io switches driven when accessing
// - debounced master/slave pulses release panel hold
// - interrupt or slave halt can revert slave
// - diagnostic flop set, cleared on master acknowledge
// - master test loads request address complemented, except in load states
// - jump pulse forwarded; destination preloaded
// - debounced reset switch drives bus reset
// - step flop frees one access, cleared trailing
// - panel hold is step hold AND request
// - second hold asserted at request trailing edge
// - step lamp on, run lamp off; master/slave lamps
`timescale 1ns/1ps
`default_nettype none
module front_panel_bus_control
  import panel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] address_switch,
  input wire logic [7:0] data_switch,
  input wire logic common_memory_switch,
  input wire logic mem_io_switch,
  input wire logic breakpoint_switch,
  input wire logic access_switch,
  input wire logic load_press,
  input wire logic address_increment,
  input wire logic address_decrement,
  input wire logic enter_press,
  input wire logic enter_next_press,
  input wire logic set_master_raw,
  input wire logic set_slave_raw,
  input wire logic diagnostic_press,
  input wire logic master_test_switch,
  input wire logic jump_press,
  input wire logic reset_raw,
  input wire logic run_step_center,
  input wire logic step_press,
  input wire logic [15:0] bus_address,
  input wire logic bus_common_memory_select,
  input wire logic operation_request,
  input wire logic bus_run,
  input wire logic slave_request,
  input wire logic master_interrupt_pending,
  input wire logic slave_halted,
  input wire logic slave_enabled,
  input wire logic master_int_ack,
  output logic [7:0] switch_path,
  output logic scope_sync,
  output logic panel_hold,
  output logic second_hold,
  output logic pause_request,
  output bus_drive_s bus_drive,
  output logic bus_drive_oe,
  output logic diagnostic_interrupt,
  output logic jump_pulse,
  output logic bus_reset_o,
  output logic bus_reset_oe,
  output logic master_active,
  output lamps_s lamps,
  output logic [15:0] address_register
);
  logic [15:0] addr_q;
  logic match;
  logic operation_request_q;
  logic operation_request_fall;
  logic operation_request_rise;
  logic [CNT_W-1:0] gap_cnt_q;
  logic [CNT_W-1:0] dsel_cnt_q;
  logic data_select;
  logic gap_active;
  logic granted;
  logic load_flag_q;
  load_state_e ld_q;
  logic hi_sel;
  logic step_ff_q;
  logic ms_release_q;
  logic set_master_p;
  logic set_slave_p;
  logic reset_clean;
  logic slave_pending_q;
  logic next_pending_q;

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  function automatic logic address_hit(input logic [15:0] a, input logic [15:0] s, input logic cm_a,
                                       input logic cm_s);
    address_hit = ((a ^ s) == 16'h0000) && (cm_a == cm_s);
  endfunction : address_hit

  ////////////////////////////////////////////////////////////////////////////
  // switch cleaning
  debounce u_db_master (.clk_sys, .sys_rst, .raw(set_master_raw), .clean(), .rise(set_master_p));
  debounce u_db_slave (.clk_sys, .sys_rst, .raw(set_slave_raw), .clean(), .rise(set_slave_p));
  debounce u_db_reset (.clk_sys, .sys_rst, .raw(reset_raw), .clean(reset_clean), .rise());

  ////////////////////////////////////////////////////////////////////////////
  // comparator and request edges
  assign match = address_hit(bus_address, address_switch, bus_common_memory_select, common_memory_switch);
  assign operation_request_fall = operation_request_q & ~operation_request;
  assign operation_request_rise = ~operation_request_q & operation_request;
  assign granted = access_switch & ~bus_run;
  assign data_select = dsel_cnt_q != '0;
  assign gap_active = gap_cnt_q != '0;
  assign hi_sel = ld_q == LD_LOW;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      operation_request_q <= 1'b0;
    end else begin
      operation_request_q <= operation_request;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scope_sync <= 1'b0;
    end else begin
      scope_sync <= match & operation_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-shots
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt_q <= '0;
    end else if (granted && (address_increment || address_decrement || enter_press || enter_next_press)) begin
      gap_cnt_q <= CNT_W'(GAP_CYCLES);
    end else if (gap_active) begin
      gap_cnt_q <= gap_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dsel_cnt_q <= '0;
    end else if (granted && (enter_press || next_pending_q)) begin
      dsel_cnt_q <= CNT_W'(DSEL_CYCLES);
    end else if (data_select) begin
      dsel_cnt_q <= dsel_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      next_pending_q <= 1'b0;
    end else begin
      next_pending_q <= granted & enter_next_press;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load sequencer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      load_flag_q <= 1'b0;
    end else if (granted && load_press) begin
      load_flag_q <= 1'b1;
    end else if (ld_q == LD_HIGH) begin
      load_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ld_q <= LD_IDLE;
    end else begin
      unique case (ld_q)
        LD_IDLE: begin
          if (load_flag_q) begin
            ld_q <= LD_LOW;
          end
        end
        LD_LOW: ld_q <= LD_HIGH;
        LD_HIGH: ld_q <= LD_IDLE;
        default: ld_q <= LD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= ADDR_RST;
    end else if (ld_q == LD_LOW) begin
      addr_q[ADDR_LO_POS +: 8] <= switch_path;
    end else if (ld_q == LD_HIGH) begin
      addr_q[ADDR_HI_POS +: 8] <= switch_path;
    end else if (master_test_switch && operation_request_rise) begin
      addr_q <= ~bus_address;
    end else if (!master_test_switch && slave_request && operation_request_rise && load_flag_q) begin
      addr_q <= ~bus_address;
    end else if (granted && (address_increment || enter_next_press)) begin
      addr_q <= addr_q + 16'h0001;
    end else if (granted && address_decrement) begin
      addr_q <= addr_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      address_register <= ADDR_RST;
    end else begin
      address_register <= addr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch multiplexer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      switch_path <= 8'h00;
    end else if (data_select || (granted && enter_press)) begin
      switch_path <= data_switch;
    end else begin
      switch_path <= hi_sel ? address_switch[ADDR_HI_POS +: 8] : address_switch[ADDR_LO_POS +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drive during access
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pause_request <= 1'b0;
      bus_drive_oe <= 1'b0;
      bus_drive <= '0;
    end else begin
      pause_request <= access_switch;
      bus_drive_oe <= granted;
      bus_drive.addr <= addr_q;
      bus_drive.common_memory_select <= common_memory_switch;
      bus_drive.mem_not_io <= mem_io_switch;
      bus_drive.operation_request <= granted & ~gap_active;
      bus_drive.write_line <= data_select;
      bus_drive.write_strobe_pulse <= data_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master/slave control
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      master_active <= 1'b1;
      slave_pending_q <= 1'b0;
    end else if (set_master_p) begin
      master_active <= 1'b1;
      slave_pending_q <= 1'b0;
    end else if (set_slave_p) begin
      master_active <= ~(slave_enabled & ~master_interrupt_pending);
      slave_pending_q <= 1'b1;
    end else if (slave_pending_q && (master_interrupt_pending || slave_halted)) begin
      master_active <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ms_release_q <= 1'b0;
    end else begin
      ms_release_q <= set_master_p | set_slave_p;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostic interrupt and jump
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      diagnostic_interrupt <= 1'b0;
    end else if (diagnostic_press) begin
      diagnostic_interrupt <= 1'b1;
    end else if (master_int_ack) begin
      diagnostic_interrupt <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      jump_pulse <= 1'b0;
    end else begin
      jump_pulse <= jump_press;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset and stepping
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bus_reset_o <= 1'b0;
      bus_reset_oe <= 1'b0;
    end else begin
      bus_reset_o <= reset_clean;
      bus_reset_oe <= reset_clean;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      step_ff_q <= 1'b0;
    end else if (step_press) begin
      step_ff_q <= 1'b1;
    end else if (operation_request_fall) begin
      step_ff_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      panel_hold <= 1'b0;
      second_hold <= 1'b0;
    end else begin
      panel_hold <= ((run_step_center & ~step_ff_q & operation_request)
                     | (breakpoint_switch & match & operation_request)) & ~ms_release_q;
      if (!run_step_center || step_press) begin
        second_hold <= 1'b0;
      end else if (operation_request_fall) begin
        second_hold <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lamps <= '0;
    end else begin
      lamps.run_lamp <= ~run_step_center;
      lamps.step_lamp <= run_step_center;
      lamps.master_lamp <= master_active;
      lamps.slave_lamp <= ~master_active;
      lamps.test_lamp <= master_test_switch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence load_tail;
    (ld_q == LD_HIGH) ##1 (ld_q == LD_IDLE);
  endsequence : load_tail
  a_sync_match: assert property ((match && operation_request) |=> scope_sync) else $error("sync missing");
  a_gap_width: assert property ((granted && address_increment) |=> gap_active [*8])
    else $error("gap short");
  a_write_follows: assert property (data_select |=> bus_drive.write_strobe_pulse)
    else $error("no strobe");
  a_diag_set: assert property (diagnostic_press |=> diagnostic_interrupt) else $error("diag not set");
  a_hold_needs_req: assert property (panel_hold |-> $past(operation_request))
    else $error("hold without request");
  a_second_hold: assert property ((operation_request_fall && run_step_center && !step_press) |=> second_hold)
    else $error("second hold late");
  a_step_clear: assert property ((operation_request_fall && !step_press) |=> !step_ff_q)
    else $error("step not cleared");
  a_load_order: assert property ((ld_q == LD_LOW) |=> load_tail) else $error("load order");
  a_reset_drive: assert property (reset_clean |=> bus_reset_oe) else $error("reset not driven");
  a_ms_release: assert property (ms_release_q |=> !panel_hold) else $error("hold not released");
endmodule : front_panel_bus_control
`default_nettype wire

// file: bench/bus_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_cpu_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] addr_in,
  input wire logic cm_in,
  input wire logic [7:0] len,
  input wire logic pause_request,
  input wire logic panel_hold,
  input wire logic jump_pulse,
  input wire logic [15:0] address_register,
  output logic [15:0] bus_address,
  output logic bus_common_memory_select,
  output logic operation_request,
  output logic bus_run,
  output logic [15:0] jump_target_q
);
  logic [7:0] cnt_q;
  logic [2:0] pause_q;
  ////////////////////////////////////////////////////////////
  // cpu ends its instruction, then stops running
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pause_q <= 3'b000;
      bus_run <= 1'b1;
    end else begin
      pause_q <= {pause_q[1:0], pause_request};
      bus_run <= !pause_q[2];
    end
  end
  ////////////////////////////////////////////////////////////
  // one bus access, frozen while panel hold is up; released lines toggle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      operation_request <= 1'b0;
      bus_address <= 16'h0000;
      bus_common_memory_select <= 1'b0;
    end else if (start && bus_run) begin
      cnt_q <= len;
      operation_request <= 1'b1;
      bus_address <= addr_in;
      bus_common_memory_select <= cm_in;
    end else if (operation_request) begin
      if (!panel_hold) begin
        cnt_q <= cnt_q - 8'h01;
        operation_request <= (cnt_q != 8'h01);
      end
    end else begin
      bus_address <= ~bus_address;
      bus_common_memory_select <= ~bus_common_memory_select;
    end
  end
  ////////////////////////////////////////////////////////////
  // slave takes its jump destination from the address register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      jump_target_q <= 16'h0000;
    end else if (jump_pulse) begin
      jump_target_q <= address_register;
    end
  end
endmodule : bus_cpu_model
`default_nettype wire

// file: bench/front_panel_bus_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module front_panel_bus_control_tb;
  import panel_pkg::*;
  typedef struct {int s; logic [15:0] e;} note_s;
  logic clk_sys = '0;
  logic sys_rst = 1'b1;
  logic [15:0] address_switch = '0;
  logic [7:0] data_switch = '0;
  logic common_memory_switch = '0, mem_io_switch = '0, breakpoint_switch = '0, access_switch = '0;
  logic load_press = '0, address_increment = '0, address_decrement = '0, enter_press = '0;
  logic enter_next_press = '0, set_master_raw = '0, set_slave_raw = '0, diagnostic_press = '0;
  logic master_test_switch = '0, jump_press = '0, reset_raw = '0, run_step_center = '0, step_press = '0;
  logic slave_enabled = '0, master_int_ack = '0, master_interrupt_pending = '0, slave_halted = '0;
  logic start = '0, cyc_cm = '0, slave_request = '0;
  logic [15:0] cyc_addr = '0;
  logic [7:0] cyc_len = 8'h02;
  logic [15:0] bus_address, address_register, jump_target_q, a;
  logic bus_common_memory_select, operation_request, bus_run, scope_sync, panel_hold, second_hold;
  logic pause_request, bus_drive_oe, diagnostic_interrupt, jump_pulse, bus_reset_o, bus_reset_oe;
  logic master_active;
  logic [7:0] switch_path;
  bus_drive_s bus_drive;
  lamps_s lamps;
  logic [15:0] o [15];
  logic [15:0] jumps_q = '0;
  logic [31:0] lfsr_q = 32'h7f34_72f6;
  note_s q[$];
  int bad_count = 0;
  int samples_checked = 0;
  ////////////////////////////////////////////////////////////
  front_panel_bus_control i_front_panel_bus_control (
    .clk_sys, .sys_rst, .address_switch, .data_switch, .common_memory_switch, .mem_io_switch,
    .breakpoint_switch, .access_switch, .load_press, .address_increment, .address_decrement,
    .enter_press, .enter_next_press, .set_master_raw, .set_slave_raw, .diagnostic_press,
    .master_test_switch, .jump_press, .reset_raw, .run_step_center, .step_press, .bus_address,
    .bus_common_memory_select, .operation_request, .bus_run, .slave_request,
    .master_interrupt_pending, .slave_halted, .slave_enabled, .master_int_ack, .switch_path,
    .scope_sync, .panel_hold, .second_hold, .pause_request, .bus_drive, .bus_drive_oe,
    .diagnostic_interrupt, .jump_pulse, .bus_reset_o, .bus_reset_oe, .master_active, .lamps,
    .address_register
  );
  bus_cpu_model i_bus_cpu_model (
    .clk_sys, .sys_rst, .start, .addr_in(cyc_addr), .cm_in(cyc_cm), .len(cyc_len), .pause_request,
    .panel_hold, .jump_pulse, .address_register, .bus_address, .bus_common_memory_select,
    .operation_request, .bus_run, .jump_target_q
  );
  assign o[0] = address_register;
  assign o[1] = 16'(switch_path);
  assign o[2] = bus_drive.addr;
  assign o[3] = 16'(lamps[3:0]);
  assign o[4] = 16'(scope_sync);
  assign o[5] = 16'(panel_hold);
  assign o[6] = 16'(second_hold);
  assign o[7] = 16'(pause_request);
  assign o[8] = 16'(master_active);
  assign o[9] = 16'(diagnostic_interrupt);
  assign o[10] = jumps_q;
  assign o[11] = 16'({bus_reset_o, bus_reset_oe});
  assign o[12] = 16'({bus_drive_oe, bus_drive[4:0]});
  assign o[13] = jump_target_q;
  assign o[14] = 16'(lamps.run_lamp);
  ////////////////////////////////////////////////////////////
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (jump_pulse === 1'b1) jumps_q <= jumps_q + 16'h0001;
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic cy(int n);
    repeat (n) @(negedge clk_sys);
  endtask : cy
  task automatic pulse(ref logic s);
    s = 1'b1;
    cy(1);
    s = 1'b0;
  endtask : pulse
  task automatic ms(ref logic s);
    s = 1'b1;
    cy(1100);
    s = 1'b0;
    cy(1100);
  endtask : ms
  task automatic bus_cycle(logic [15:0] ad, logic cm, logic [7:0] n);
    cyc_addr = ad;
    cyc_cm = cm;
    cyc_len = n;
    pulse(start);
  endtask : bus_cycle
  task automatic note(int s, logic [15:0] e);
    q.push_back('{s, e});
  endtask : note
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////
  // watcher: compares every queued note against its output, oldest first
  always @(negedge clk_sys) begin
    #1;
    while (q.size() > 0) begin
      check(o[q[0].s], q[0].e);
      void'(q.pop_front());
    end
  end
  initial begin
    #150000;
    bad_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    cy(2);
    sys_rst = 1'b0;
    cy(2);
    note(8, 16'h0001);
    note(5, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      lfsr_q = nxt(lfsr_q);
      address_switch = lfsr_q[15:0];
      common_memory_switch = lfsr_q[16];
      breakpoint_switch = i[0];
      a = address_switch ^ ((i == 4) ? 16'h0001 << lfsr_q[20:17] : 16'h0000);
      bus_cycle(a, common_memory_switch ^ (i == 5), 8'h14);
      cy(4);
      note(4, 16'(i < 4));
      note(5, 16'(i < 4 && i[0]));
      breakpoint_switch = 1'b0;
      cy(30);
    end
    $display("breakpoint test done");
    access_switch = 1'b1;
    cy(3);
    note(7, 16'h0001);
    mem_io_switch = 1'b1;
    common_memory_switch = 1'b1;
    address_switch = 16'h12ff;
    cy(10);
    pulse(load_press);
    cy(8);
    note(0, 16'h12ff);
    note(2, 16'h12ff);
    note(12, 16'h0039);
    pulse(address_increment);
    cy(3);
    note(0, 16'h1300);
    note(12, 16'h0031);
    cy(190);
    note(12, 16'h0031);
    cy(12);
    note(12, 16'h0039);
    pulse(address_decrement);
    cy(3);
    note(0, 16'h12ff);
    cy(210);
    for (int k = 0; k < 2; k++) begin
      lfsr_q = nxt(lfsr_q);
      data_switch = lfsr_q[7:0];
      if (k == 0) pulse(enter_next_press);
      else pulse(enter_press);
      cy(4);
      note(0, 16'h1300);
      note(1, 16'(data_switch));
      note(12, 16'h0037);
      cy(1990);
      note(12, 16'h003f);
      cy(20);
      note(12, 16'h0039);
    end
    access_switch = 1'b0;
    cy(10);
    $display("access test done");
    slave_enabled = 1'b1;
    ms(set_slave_raw);
    note(8, 16'h0000);
    note(3, 16'h0002);
    ms(set_master_raw);
    note(8, 16'h0001);
    ms(set_slave_raw);
    master_interrupt_pending = 1'b1;
    cy(4);
    note(8, 16'h0001);
    master_interrupt_pending = 1'b0;
    ms(set_slave_raw);
    slave_halted = 1'b1;
    cy(4);
    note(8, 16'h0001);
    slave_halted = 1'b0;
    slave_enabled = 1'b0;
    ms(set_slave_raw);
    note(8, 16'h0001);
    $display("master slave test done");
    pulse(diagnostic_press);
    cy(20);
    note(9, 16'h0001);
    pulse(master_int_ack);
    cy(3);
    note(9, 16'h0000);
    pulse(jump_press);
    cy(4);
    note(10, 16'h0001);
    note(13, 16'h1300);
    reset_raw = 1'b1;
    cy(1100);
    note(11, 16'h0003);
    reset_raw = 1'b0;
    cy(1100);
    note(11, 16'h0000);
    $display("cpu control test done");
    run_step_center = 1'b1;
    cy(3);
    note(5, 16'h0000);
    note(3, 16'h000c);
    note(14, 16'h0000);
    bus_cycle(16'h1234, 1'b0, 8'h0a);
    cy(4);
    note(5, 16'h0001);
    cy(20);
    note(5, 16'h0001);
    pulse(step_press);
    cy(2);
    note(5, 16'h0000);
    for (int i = 0; i < 40 && operation_request; i++) cy(1);
    cy(2);
    note(6, 16'h0001);
    bus_cycle(16'h4321, 1'b0, 8'h0a);
    cy(4);
    note(5, 16'h0001);
    run_step_center = 1'b0;
    cy(30);
    master_test_switch = 1'b1;
    slave_request = 1'b1;
    cy(2);
    lfsr_q = nxt(lfsr_q);
    a = ~lfsr_q[15:0];
    bus_cycle(lfsr_q[15:0], 1'b0, 8'h08);
    cy(15);
    note(0, a);
    note(3, 16'h0005);
    master_test_switch = 1'b0;
    slave_request = 1'b0;
    cy(2);
    bus_cycle(~lfsr_q[31:16], 1'b0, 8'h08);
    cy(15);
    note(0, a);
    cy(3);
    $display("step and test done");
    stop_test();
  end
endmodule : front_panel_bus_control_tb
`default_nettype wire
